// [design/sxs_defines.svh]
// Constants for the shift, exchange and stack operation unit.
// Assumes a core sequencer that issues one operation at a time.
// Function
// - Left logical shift: zero into bit 0, bits up, old MSB to carry.
// - Right arithmetic shift: MSB kept, bits down, old bit 0 to carry.
// - Right logical shift: zero into MSB, bits down, old bit 0 to carry.
// - Nibble swap exchanges accumulator halves; 1 byte, 2 states both modes.
// - Left shift of byte or word: 3 bytes 2 states binary, 2 bytes 1 state source.
// - Right shifts: 3 bytes 2 states binary, 2 bytes 1 state source.
// - Direct exchange 2 bytes 3 states; register exchange 1/3 binary, 2/4 source.
// - Indirect exchange: 1 byte 4 states binary, 2 bytes 5 states source.
// - Low nibble exchange, 256-byte indirect space; 1/4 binary, 2/5 source.
// - Push direct byte: 2 bytes and 2 states in both modes.
// - Push 8-bit immediate: 4 bytes 4 states binary, 3 bytes 3 states source.
// - Push 16-bit immediate: 5 bytes 5 states binary, 4 bytes 5 states source.
// - Push byte register: 3 bytes 4 states binary, 2 bytes 3 states source.
// - Push word register: 3 bytes 5 states binary, 2 bytes 4 states source.
// - Push dword register: 3 bytes 9 states binary, 2 bytes 8 states source.
// - Pop to direct location: 2 bytes and 3 states in both modes.
// - Pop byte register: 3 bytes 3 states binary, 2 bytes 2 states source.
// - Pop word register: 3 bytes 5 states binary, 2 bytes 4 states source.
// - Pop dword register: 3 bytes 9 states binary, 2 bytes 8 states source.
// - Direct push or pop adds 1 state for I/O port, 2 for peripheral.
// - Direct exchange adds 2 states for I/O port, 3 for peripheral.
`ifndef SXS_DEFINES_SVH
`define SXS_DEFINES_SVH
`define SXS_IO_ADD_PP 4'h1
`define SXS_PER_ADD_PP 4'h2
`define SXS_IO_ADD_XCH 4'h2
`define SXS_PER_ADD_XCH 4'h3
`endif

// [design/sxs_pkg.sv]
// Types for the shift, exchange and stack operation unit.
// Assumes sxs_defines.svh is compiled alongside.
package sxs_pkg;
   typedef enum logic [4:0] {
      SXS_SLL_B, SXS_SLL_W, SXS_SRA_B, SXS_SRA_W, SXS_SRL_B, SXS_SRL_W, SXS_SWAP,
      SXS_XCH_RN, SXS_XCH_DIR, SXS_XCH_IND, SXS_ACC_LOW_NIBBLE_EXCHANGE_IND,
      SXS_PUSH_DIR, SXS_PUSH_IMM8, SXS_PUSH_IMM16, SXS_PUSH_RM, SXS_PUSH_WR, SXS_PUSH_DR,
      SXS_POP_DIR, SXS_POP_RM, SXS_POP_WR, SXS_POP_DR
   } sxs_op_type;
   typedef enum logic [1:0] {SXS_LOC_RAM, SXS_LOC_IO, SXS_LOC_PER} sxs_loc_type;
   typedef struct packed {
      sxs_op_type op;
      logic source_mode;
      sxs_loc_type loc;
      logic [15:0] operand;
      logic [7:0] accumulator;
      logic [7:0] mem_byte;
   } sxs_req_type;
   typedef struct packed {
      logic [15:0] result;
      logic [7:0] accumulator;
      logic [7:0] mem_byte;
      logic carry_flag;
      logic carry_valid;
      logic [2:0] length;
      logic [3:0] states;
   } sxs_rsp_type;
endpackage : sxs_pkg

// [design/sxs_unit.sv]
// Shift, exchange and stack operation unit: computes data results and
// occupies the issue slot for the documented number of states.
// Assumes one state per mclk and a sequencer that waits for done.
`include "sxs_defines.svh"
module sxs_unit import sxs_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire sxs_req_type req,
   output logic busy,
   output logic done,
   output sxs_rsp_type rsp
);
   ////////////////////////////////////////////////////////////////
   // Timing table
   logic [2:0] len_w;
   logic [3:0] base_w;
   logic [3:0] add_w;
   logic m;
   assign m = req.source_mode;
   always_comb begin
      len_w = 3'h0;
      base_w = 4'h1;
      unique case (req.op)
         SXS_SLL_B, SXS_SLL_W: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h1 : 4'h2;
         end
         SXS_SRA_B, SXS_SRA_W, SXS_SRL_B, SXS_SRL_W: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h1 : 4'h2;
         end
         SXS_SWAP: begin
            len_w = 3'h1;
            base_w = 4'h2;
         end
         SXS_XCH_RN: begin
            len_w = m ? 3'h2 : 3'h1;
            base_w = m ? 4'h4 : 4'h3;
         end
         SXS_XCH_DIR: begin
            len_w = 3'h2;
            base_w = 4'h3;
         end
         SXS_XCH_IND: begin
            len_w = m ? 3'h2 : 3'h1;
            base_w = m ? 4'h5 : 4'h4;
         end
         SXS_ACC_LOW_NIBBLE_EXCHANGE_IND: begin
            len_w = m ? 3'h2 : 3'h1;
            base_w = m ? 4'h5 : 4'h4;
         end
         SXS_PUSH_DIR: begin
            len_w = 3'h2;
            base_w = 4'h2;
         end
         SXS_PUSH_IMM8: begin
            len_w = m ? 3'h3 : 3'h4;
            base_w = m ? 4'h3 : 4'h4;
         end
         SXS_PUSH_IMM16: begin
            len_w = m ? 3'h4 : 3'h5;
            base_w = 4'h5;
         end
         SXS_PUSH_RM: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h3 : 4'h4;
         end
         SXS_PUSH_WR: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h4 : 4'h5;
         end
         SXS_PUSH_DR: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h8 : 4'h9;
         end
         SXS_POP_DIR: begin
            len_w = 3'h2;
            base_w = 4'h3;
         end
         SXS_POP_RM: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h2 : 4'h3;
         end
         SXS_POP_WR: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h4 : 4'h5;
         end
         SXS_POP_DR: begin
            len_w = m ? 3'h2 : 3'h3;
            base_w = m ? 4'h8 : 4'h9;
         end
         default: begin
            len_w = 3'h0;
            base_w = 4'h1;
         end
      endcase
   end
   logic is_pp_dir;
   logic is_xch_dir;
   assign is_pp_dir = (req.op == SXS_PUSH_DIR) || (req.op == SXS_POP_DIR);
   assign is_xch_dir = (req.op == SXS_XCH_DIR);
   assign add_w = (req.loc == SXS_LOC_IO) ?
                  (is_pp_dir ? `SXS_IO_ADD_PP : (is_xch_dir ? `SXS_IO_ADD_XCH : 4'h0)) :
                  (req.loc == SXS_LOC_PER) ?
                  (is_pp_dir ? `SXS_PER_ADD_PP : (is_xch_dir ? `SXS_PER_ADD_XCH : 4'h0)) : 4'h0;
   logic [3:0] states_w;
   assign states_w = base_w + add_w;

   ////////////////////////////////////////////////////////////////
   // Data path
   logic [15:0] d;
   logic [7:0] a;
   logic [7:0] mb;
   assign d = req.operand;
   assign a = req.accumulator;
   assign mb = req.mem_byte;
   logic [15:0] res_w;
   logic [7:0] acc_w;
   logic [7:0] mem_w;
   logic cy_w;
   logic cyv_w;
   always_comb begin
      res_w = d;
      acc_w = a;
      mem_w = mb;
      cy_w = 1'b0;
      cyv_w = 1'b0;
      unique case (req.op)
         SXS_SLL_B: begin
            res_w = {8'h00, d[6:0], 1'b0};
            cy_w = d[7];
            cyv_w = 1'b1;
         end
         SXS_SLL_W: begin
            res_w = {d[14:0], 1'b0};
            cy_w = d[15];
            cyv_w = 1'b1;
         end
         SXS_SRA_B: begin
            res_w = {8'h00, d[7], d[7:1]};
            cy_w = d[0];
            cyv_w = 1'b1;
         end
         SXS_SRA_W: begin
            res_w = {d[15], d[15:1]};
            cy_w = d[0];
            cyv_w = 1'b1;
         end
         SXS_SRL_B: begin
            res_w = {8'h00, 1'b0, d[7:1]};
            cy_w = d[0];
            cyv_w = 1'b1;
         end
         SXS_SRL_W: begin
            res_w = {1'b0, d[15:1]};
            cy_w = d[0];
            cyv_w = 1'b1;
         end
         SXS_SWAP: acc_w = {a[3:0], a[7:4]};
         SXS_XCH_RN, SXS_XCH_DIR, SXS_XCH_IND: begin
            acc_w = mb;
            mem_w = a;
         end
         SXS_ACC_LOW_NIBBLE_EXCHANGE_IND: begin
            acc_w = {a[7:4], mb[3:0]};
            mem_w = {mb[7:4], a[3:0]};
         end
         default: res_w = d;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Sequencing
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic busy_q;
   logic done_q;
   sxs_rsp_type rsp_q;
   logic take;
   assign take = start && !busy_q;
   assign cnt_d = take ? states_w - 4'h1 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= take ? 1'b1 : (busy_q && cnt_q != 4'h0);
         done_q <= take ? (states_w == 4'h1) : (busy_q && cnt_q == 4'h1);
         if (take) begin
            rsp_q <= '{res_w, acc_w, mem_w, cy_w, cyv_w, len_w, states_w};
         end
      end
   end
   assign busy = busy_q;
   assign done = done_q;
   assign rsp = rsp_q;

   ////////////////////////////////////////////////////////////////
   // Checks
   sequence issue_s;
      take;
   endsequence
   swap_timing_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SWAP) |=> !done ##1 done) else $error("swap not done in 2 states");
   sll_carry_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SLL_B) |=> (rsp.carry_flag == $past(req.operand[7]) && rsp.result[0] == 1'b0))
      else $error("left shift carry wrong");
   sra_msb_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SRA_W) |=> rsp.result[15] == $past(req.operand[15]))
      else $error("arithmetic shift msb lost");
   srl_msb_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SRL_B) |=> (rsp.result[7] == 1'b0 && rsp.carry_flag == $past(req.operand[0])))
      else $error("logical right shift wrong");
   push_dword_a: assert property (@(posedge mclk) disable iff (!rstn)
      (issue_s ##0 (req.op == SXS_PUSH_DR && !req.source_mode)) |=> !done [*8] ##1 done)
      else $error("dword push not 9 states");
   pp_io_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_DIR && req.loc == SXS_LOC_IO) |=> rsp.states == 4'h3)
      else $error("io push penalty wrong");
   xch_per_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_XCH_DIR && req.loc == SXS_LOC_PER) |=> rsp.states == 4'h6)
      else $error("peripheral exchange penalty wrong");
   acc_low_nibble_exchange_data_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_ACC_LOW_NIBBLE_EXCHANGE_IND) |=> (rsp.accumulator[7:4] == $past(req.accumulator[7:4])
      && rsp.mem_byte[3:0] == $past(req.accumulator[3:0]))) else $error("nibble exchange wrong");
   push_imm16_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_IMM16 && req.source_mode) |=> (rsp.length == 3'h4 && rsp.states == 4'h5))
      else $error("imm16 push size wrong");
   sll_src_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SLL_B && req.source_mode) |=> done)
      else $error("source left shift not 1 state");
   srl_bin_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SRL_W && !req.source_mode) |=> !done ##1 done)
      else $error("binary right shift not 2 states");
   xch_rn_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_XCH_RN && req.source_mode) |=> (rsp.length == 3'h2 && rsp.states == 4'h4))
      else $error("register exchange size wrong");
   xch_ind_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_XCH_IND && !req.source_mode) |=> (rsp.length == 3'h1 && rsp.states == 4'h4))
      else $error("indirect exchange size wrong");
   push_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_DIR && req.loc == SXS_LOC_RAM) |=> !done ##1 done)
      else $error("direct push not 2 states");
   push_imm8_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_IMM8 && !req.source_mode) |=> (rsp.length == 3'h4 && rsp.states == 4'h4))
      else $error("imm8 push size wrong");
   push_rm_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_RM && req.source_mode) |=> (rsp.length == 3'h2 && rsp.states == 4'h3))
      else $error("byte push size wrong");
   push_wr_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_PUSH_WR && !req.source_mode) |=> (rsp.length == 3'h3 && rsp.states == 4'h5))
      else $error("word push size wrong");
   pop_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_POP_DIR && req.loc == SXS_LOC_RAM) |=> (rsp.length == 3'h2 && rsp.states == 4'h3))
      else $error("direct pop size wrong");
   pop_rm_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_POP_RM && req.source_mode) |=> (rsp.length == 3'h2 && rsp.states == 4'h2))
      else $error("byte pop size wrong");
   pop_wr_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_POP_WR && req.source_mode) |=> (rsp.length == 3'h2 && rsp.states == 4'h4))
      else $error("word pop size wrong");
   pop_dword_a: assert property (@(posedge mclk) disable iff (!rstn)
      (issue_s ##0 (req.op == SXS_POP_DR && req.source_mode)) |=> !done [*7] ##1 done)
      else $error("dword pop not 8 states");
   pp_per_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_POP_DIR && req.loc == SXS_LOC_PER) |=> rsp.states == 4'h5)
      else $error("peripheral pop penalty wrong");
   sll_word_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && req.op == SXS_SLL_W) |=> rsp.carry_flag == $past(req.operand[15]))
      else $error("word left shift carry wrong");
   done_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
      done |-> busy)
      else $error("done outside busy");
endmodule : sxs_unit

// [verification/tb_sxs_unit.sv]
// Self-checking bench for the shift, exchange and stack operation unit.
// Assumes sxs_pkg is compiled first; the bench alone drives every input port.
module tb_sxs_unit import sxs_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {sxs_rsp_type r; logic [1:0] kind;} sxs_exp_type;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   sxs_req_type req = '0;
   logic busy, done, busy_prev;
   sxs_rsp_type rsp;
   int fails = 0, cmp_count = 0, cyc = 0, t_take = 0;
   integer seed = 32'h55d9;
   sxs_exp_type exq[$];
   sxs_exp_type ce;
   // Nibbles: binary bytes, binary states, source bytes, source states
   logic [15:0] lens [0:20] = '{16'h3221, 16'h3221, 16'h3221, 16'h3221, 16'h3221, 16'h3221, 16'h1212,
      16'h1324, 16'h2323, 16'h1425, 16'h1425, 16'h2222, 16'h4433, 16'h5545, 16'h3423, 16'h3524,
      16'h3928, 16'h2323, 16'h3322, 16'h3524, 16'h3928};

   sxs_unit i_sxs_unit (.mclk(mclk), .rstn(rstn), .start(start), .req(req), .busy(busy), .done(done), .rsp(rsp));

   always #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   function sxs_exp_type model(input sxs_req_type q);
      sxs_exp_type e;
      logic [15:0] o, t;
      logic [7:0] a, m;
      e = '0;
      o = q.operand;
      a = q.accumulator;
      m = q.mem_byte;
      t = lens[q.op];
      e.r.length = q.source_mode ? t[6:4] : t[14:12];
      e.r.states = q.source_mode ? t[3:0] : t[11:8];
      if (q.op inside {SXS_PUSH_DIR, SXS_POP_DIR})
         e.r.states += (q.loc == SXS_LOC_IO) ? 4'h1 : (q.loc == SXS_LOC_PER) ? 4'h2 : 4'h0;
      if (q.op == SXS_XCH_DIR)
         e.r.states += (q.loc == SXS_LOC_IO) ? 4'h2 : (q.loc == SXS_LOC_PER) ? 4'h3 : 4'h0;
      case (q.op)
         SXS_SLL_B: {e.r.carry_flag, e.r.result} = {o[7], 8'h00, o[6:0], 1'b0};
         SXS_SLL_W: {e.r.carry_flag, e.r.result} = {o[15], o[14:0], 1'b0};
         SXS_SRA_B: {e.r.carry_flag, e.r.result} = {o[0], 8'h00, o[7], o[7:1]};
         SXS_SRA_W: {e.r.carry_flag, e.r.result} = {o[0], o[15], o[15:1]};
         SXS_SRL_B: {e.r.carry_flag, e.r.result} = {o[0], 9'h000, o[7:1]};
         SXS_SRL_W: {e.r.carry_flag, e.r.result} = {o[0], 1'b0, o[15:1]};
         SXS_SWAP: e.r.accumulator = {a[3:0], a[7:4]};
         SXS_ACC_LOW_NIBBLE_EXCHANGE_IND: {e.r.accumulator, e.r.mem_byte} = {a[7:4], m[3:0], m[7:4], a[3:0]};
         SXS_XCH_RN, SXS_XCH_DIR, SXS_XCH_IND: {e.r.accumulator, e.r.mem_byte} = {m, a};
         default: e.kind = 2'h0;
      endcase
      e.r.carry_valid = (q.op <= SXS_SRL_W);
      e.kind = (q.op <= SXS_SRL_W) ? 2'h1 : (q.op == SXS_SWAP) ? 2'h2 : (q.op <= SXS_ACC_LOW_NIBBLE_EXCHANGE_IND) ? 2'h3 : 2'h0;
      return e;
   endfunction : model

   ////////////////////////////////////////////////////////////////////////////
   // Monitor: a take shows as busy rising; each done retires the oldest note
   always @(posedge mclk) begin
      #1;
      cyc++;
      if (busy === 1'b1 && busy_prev !== 1'b1)
         t_take = cyc;
      busy_prev = busy;
      if (done === 1'b1) begin
         if (exq.size() == 0) begin
            fails++;
            $display("MISMATCH done expected none seen 1");
         end else begin
            ce = exq.pop_front();
            chk("elapsed", 16'(cyc - t_take + 1), 16'(ce.r.states));
            chk("states", 16'(rsp.states), 16'(ce.r.states));
            chk("length", 16'(rsp.length), 16'(ce.r.length));
            chk("carry_valid", 16'(rsp.carry_valid), 16'(ce.r.carry_valid));
            if (ce.kind == 2'h1) begin
               chk("result", rsp.result, ce.r.result);
               chk("carry", 16'(rsp.carry_flag), 16'(ce.r.carry_flag));
            end
            if (ce.kind >= 2'h2)
               chk("accumulator", 16'(rsp.accumulator), 16'(ce.r.accumulator));
            if (ce.kind == 2'h3)
               chk("mem_byte", 16'(rsp.mem_byte), 16'(ce.r.mem_byte));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holds start high; junk presented while busy must be refused
   task issue(input sxs_op_type op, input logic sm, input sxs_loc_type loc, input int abort_after);
      int n;
      n = 0;
      req.op = op;
      req.source_mode = sm;
      req.loc = loc;
      req.operand = 16'($random(seed));
      req.accumulator = 8'($random(seed));
      req.mem_byte = 8'($random(seed));
      if (abort_after == 0)
         exq.push_back(model(req));
      start = 1'b1;
      while (busy !== 1'b0 && n < 40) begin @(posedge mclk); #1; n++; end
      while (busy !== 1'b1 && n < 40) begin @(posedge mclk); #1; n++; end
      req.op = sxs_op_type'(5'({$random(seed)} % 21));
      req.operand = 16'($random(seed));
      req.accumulator = 8'($random(seed));
      if (abort_after > 0)
         repeat (abort_after) begin @(posedge mclk); #1; end
      else
         while (done !== 1'b1 && n < 40) begin @(posedge mclk); #1; n++; end
      if (n >= 40) begin
         fails++;
         $display("MISMATCH issue_limit expected done seen none");
      end
   endtask : issue

   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (6) @(posedge mclk);
      #1 rstn = 1'b1;
      for (int i = 0; i < 21; i++)
         for (int m = 0; m < 2; m++)
            for (int l = 0; l < 3; l++)
               issue(sxs_op_type'(5'(i)), m[0], sxs_loc_type'(2'(l)), 0);
      start = 1'b0;
      $display("test sweep finished");
      issue(SXS_PUSH_DR, 1'b0, SXS_LOC_RAM, 3);
      start = 1'b0;
      rstn = 1'b0;
      repeat (2) begin @(posedge mclk); #1; end
      chk("busy_in_reset", 16'(busy), 16'h0000);
      chk("done_in_reset", 16'(done), 16'h0000);
      chk("rsp_in_reset", rsp.result | 16'(rsp.states), 16'h0000);
      rstn = 1'b1;
      issue(SXS_SWAP, 1'b1, SXS_LOC_RAM, 0);
      start = 1'b0;
      repeat (3) @(posedge mclk);
      chk("queue_left", 16'(exq.size()), 16'h0000);
      $display("test reset finished");
      wrap_up();
   end

   initial begin
      #100us;
      fails++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule : tb_sxs_unit
